// ### shared/pcdt_pkg.sv
// Behaviour
// - The countdown value drops by one on every 100 us tick while enabled.
// - Setting the enable bit loads the countdown from the preload value.
// - Reset and a one-to-zero change of the enable bit force all ones.
// - The preload value may be written at any time, enabled or not.
// - While enabled, a preload write restarts counting from the new value.
// - At zero the count wraps to all ones and keeps counting down.
// - Expiry sets the flag and the interrupt only when they are allowed.
// - The expiry flag is sticky; writing one clears it, zero leaves it.
`default_nettype none
package pcdt_pkg;
	localparam int unsigned TICK_US     = 100;
	localparam int unsigned CLK_MHZ     = 125;
	localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int unsigned CNT_W       = 16;
	localparam logic [15:0] CNT_RESET   = 16'hffff;
	localparam logic [15:0] PRE_RESET   = 16'hffff;
	localparam int unsigned OFS_CFG     = 32'h00;
	localparam int unsigned OFS_PRE     = 32'h04;
	localparam int unsigned OFS_CNT     = 32'h08;
	localparam int unsigned OFS_STS     = 32'h0c;
	localparam int unsigned OFS_MASK    = 32'h10;
	localparam int unsigned CFG_EN_BIT  = 0;
	localparam int unsigned STS_EXP_BIT = 0;
	localparam int unsigned MASK_EXP_BIT = 0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum {
		REG_CFG,
		REG_PRE,
		REG_CNT,
		REG_STS,
		REG_MASK,
		REG_NONE
	} pcdt_reg_t;

	typedef struct packed {
		logic        en;
		logic        allow;
		logic        flag;
		logic [CNT_W-1:0] preload;
		logic [CNT_W-1:0] count;
	} pcdt_state_t;

	localparam pcdt_state_t STATE_RESET = '{
		en: 1'b0, allow: 1'b0, flag: 1'b0,
		preload: PRE_RESET, count: CNT_RESET};
endpackage : pcdt_pkg
`default_nettype wire

// ### rtl/pcdt_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module pcdt_tick_div #(
	parameter int unsigned DIV = pcdt_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset,
	// Control
	input  wire logic run,
	input  wire logic restart,
	// Step pulse
	output logic      tick
);
	localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_tick;

	// Restart realigns so the first step after a load is a full period
	always_comb begin
		next_cnt  = cnt;
		next_tick = 1'b0;
		if (!run || restart) begin
			next_cnt = '0;
		end else if (cnt == LAST) begin
			next_cnt  = '0;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end

	property p_tick_gap;
		@(posedge sys_clk) disable iff (reset)
		tick |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("step pulses too close");
endmodule : pcdt_tick_div
`default_nettype wire

// ### rtl/pcdt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pcdt_timer #(
	parameter int unsigned TICK_CYCLES = pcdt_pkg::TICK_CYCLES,
	parameter int unsigned ADDR_W      = 8
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Interrupt
	output logic                   irq
);
	function automatic pcdt_pkg::pcdt_reg_t decode(
		input logic [ADDR_W-1:0] a
	);
		if (a == ADDR_W'(pcdt_pkg::OFS_CFG)) begin
			return pcdt_pkg::REG_CFG;
		end else if (a == ADDR_W'(pcdt_pkg::OFS_PRE)) begin
			return pcdt_pkg::REG_PRE;
		end else if (a == ADDR_W'(pcdt_pkg::OFS_CNT)) begin
			return pcdt_pkg::REG_CNT;
		end else if (a == ADDR_W'(pcdt_pkg::OFS_STS)) begin
			return pcdt_pkg::REG_STS;
		end else if (a == ADDR_W'(pcdt_pkg::OFS_MASK)) begin
			return pcdt_pkg::REG_MASK;
		end else begin
			return pcdt_pkg::REG_NONE;
		end
	endfunction : decode

	// Bus slave state
	logic              aw_full;
	logic [ADDR_W-1:0] aw_addr;
	logic              w_full;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              next_aw_full;
	logic [ADDR_W-1:0] next_aw_addr;
	logic              next_w_full;
	logic [31:0]       next_w_data;
	logic [3:0]        next_w_strb;
	logic              next_awready;
	logic              next_wready;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_arready;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;
	logic              take_aw;
	logic              take_w;
	logic              take_ar;
	logic              do_write;
	pcdt_pkg::pcdt_reg_t wsel;
	pcdt_pkg::pcdt_reg_t rsel;

	// Timer state
	pcdt_pkg::pcdt_state_t st;
	pcdt_pkg::pcdt_state_t next_st;
	logic              next_irq;
	logic              en_rise;
	logic              en_fall;
	logic              pre_wr;
	logic              reload;
	logic              expiry;
	logic              sts_clr;
	logic              tick;

	// Write path holds address and data apart so either may come first
	always_comb begin
		take_aw      = s_axi_awvalid && s_axi_awready;
		take_w       = s_axi_wvalid && s_axi_wready;
		take_ar      = s_axi_arvalid && s_axi_arready;
		do_write     = aw_full && w_full && !s_axi_bvalid;
		wsel         = decode(aw_addr);
		rsel         = decode(s_axi_araddr);
		next_aw_full = (aw_full && !do_write) || take_aw;
		next_w_full  = (w_full && !do_write) || take_w;
		next_aw_addr = take_aw ? s_axi_awaddr : aw_addr;
		next_w_data  = take_w ? s_axi_wdata : w_data;
		next_w_strb  = take_w ? s_axi_wstrb : w_strb;
		next_awready = !next_aw_full;
		next_wready  = !next_w_full;
		next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
		next_bresp   = s_axi_bresp;
		if (do_write) begin
			next_bresp = (wsel == pcdt_pkg::REG_NONE) ?
				pcdt_pkg::RESP_SLVERR : pcdt_pkg::RESP_OKAY;
		end
		next_rvalid  = take_ar || (s_axi_rvalid && !s_axi_rready);
		next_arready = !next_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (take_ar) begin
			next_rresp = pcdt_pkg::RESP_OKAY;
			case (rsel)
				pcdt_pkg::REG_CFG:  next_rdata = 32'(st.en);
				pcdt_pkg::REG_PRE:  next_rdata = 32'(st.preload);
				pcdt_pkg::REG_CNT:  next_rdata = 32'(st.count);
				pcdt_pkg::REG_STS:  next_rdata = 32'(st.flag);
				pcdt_pkg::REG_MASK: next_rdata = 32'(st.allow);
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = pcdt_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aw_full       <= 1'b0;
			aw_addr       <= '0;
			w_full        <= 1'b0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= pcdt_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= pcdt_pkg::RESP_OKAY;
		end else begin
			aw_full       <= next_aw_full;
			aw_addr       <= next_aw_addr;
			w_full        <= next_w_full;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	always_comb begin
		next_st = st;
		pre_wr  = 1'b0;
		sts_clr = 1'b0;
		expiry  = 1'b0;
		if (do_write) begin
			case (wsel)
				pcdt_pkg::REG_CFG: begin
					if (w_strb[0]) begin
						next_st.en = w_data[pcdt_pkg::CFG_EN_BIT];
					end
				end
				pcdt_pkg::REG_PRE: begin
					// Accepted whether running or stopped
					for (int b = 0; b < 2; b++) begin
						if (w_strb[b]) begin
							next_st.preload[8*b +: 8] = w_data[8*b +: 8];
						end
					end
					pre_wr = |w_strb[1:0];
				end
				pcdt_pkg::REG_STS: begin
					sts_clr = w_strb[0] && w_data[pcdt_pkg::STS_EXP_BIT];
				end
				pcdt_pkg::REG_MASK: begin
					if (w_strb[0]) begin
						next_st.allow = w_data[pcdt_pkg::MASK_EXP_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		en_rise = next_st.en && !st.en;
		en_fall = st.en && !next_st.en;
		reload  = en_rise || (st.en && pre_wr);
		if (en_fall) begin
			next_st.count = pcdt_pkg::CNT_RESET;
		end else if (reload) begin
			next_st.count = next_st.preload;
		end else if (st.en && tick) begin
			if (st.count == 16'h0000) begin
				next_st.count = pcdt_pkg::CNT_RESET;
				expiry        = 1'b1;
			end else begin
				next_st.count = st.count - 16'h0001;
			end
		end
		if (sts_clr) begin
			next_st.flag = 1'b0;
		end
		// A new allowed expiry beats a clear in the same cycle
		if (expiry && st.allow) begin
			next_st.flag = 1'b1;
		end
		next_irq = next_st.flag && next_st.allow;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st  <= pcdt_pkg::STATE_RESET;
			irq <= 1'b0;
		end else begin
			st  <= next_st;
			irq <= next_irq;
		end
	end

	pcdt_tick_div #(
		.DIV     (TICK_CYCLES)
	) u_div (
		.sys_clk (sys_clk),
		.reset   (reset),
		.run     (st.en),
		.restart (reload),
		.tick    (tick)
	);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	property p_dec;
		st.en && tick && st.count != 16'h0000 && !en_fall && !reload
		|=> st.count == $past(st.count) - 16'h0001;
	endproperty
	a_dec: assert property (p_dec)
		else $error("count did not step down on tick");

	property p_load;
		en_rise |=> st.en && st.count == st.preload;
	endproperty
	a_load: assert property (p_load)
		else $error("enable did not load preload");

	property p_fall;
		en_fall |=> !st.en && st.count == 16'hffff;
	endproperty
	a_fall: assert property (p_fall)
		else $error("disable did not force all ones");

	property p_rst;
		disable iff (1'b0)
		reset |=> st.count == 16'hffff && !st.en && !irq;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset did not force all ones");

	property p_idle_pre;
		pre_wr && !st.en && !en_rise |=> $stable(st.count) ##0 !st.en;
	endproperty
	a_idle_pre: assert property (p_idle_pre)
		else $error("idle preload write disturbed count");

	property p_restart;
		st.en && pre_wr && !en_fall
		|=> st.count == st.preload ##1 st.count == $past(st.count);
	endproperty
	a_restart: assert property (p_restart)
		else $error("preload write did not restart count");

	property p_wrap;
		st.en && tick && st.count == 16'h0000 && !en_fall && !reload
		|=> st.count == 16'hffff && st.en;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("count did not wrap at zero");

	property p_masked;
		!st.allow && !st.flag |=> !st.flag && !irq;
	endproperty
	a_masked: assert property (p_masked)
		else $error("flag rose while not allowed");

	property p_fire;
		// A mask write in the expiry cycle may drop the line at once
		expiry && st.allow |=> st.flag && irq == st.allow;
	endproperty
	a_fire: assert property (p_fire)
		else $error("allowed expiry did not raise flag");

	property p_sticky;
		st.flag && !sts_clr |=> st.flag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag dropped without clear");

	property p_w1c;
		sts_clr && !expiry |=> !st.flag && !irq;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear flag");

	c_expiry: cover property (expiry && st.allow);
	c_restart: cover property (st.en && pre_wr);
	c_race: cover property (sts_clr && expiry && st.allow);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : pcdt_timer
`default_nettype wire

// ### dv/pcdt_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcdt_timer_tb;
	localparam int unsigned TICK  = 20;
	localparam int unsigned LIMIT = 2000;
	localparam logic [7:0]  A_CFG = 8'(pcdt_pkg::OFS_CFG);
	localparam logic [7:0]  A_PRE = 8'(pcdt_pkg::OFS_PRE);
	localparam logic [7:0]  A_CNT = 8'(pcdt_pkg::OFS_CNT);
	localparam logic [7:0]  A_STS = 8'(pcdt_pkg::OFS_STS);
	localparam logic [7:0]  A_MSK = 8'(pcdt_pkg::OFS_MASK);
	localparam logic [1:0]  OK    = pcdt_pkg::RESP_OKAY;
	localparam logic [1:0]  ERR   = pcdt_pkg::RESP_SLVERR;

	logic        sys_clk;
	logic        reset;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        irq;
	int          fail_count;
	int          checks;
	int          cycles;
	logic [31:0] rd_val;
	logic [1:0]  resp;
	logic [3:0]  wr_strb;

	pcdt_timer #(.TICK_CYCLES(TICK), .ADDR_W(8)) u_dut (
		.sys_clk(sys_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.irq(irq)
	);

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	task automatic end_sim();
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count = fail_count + 1;
			end_sim();
		end
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge sys_clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= wr_strb;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid === 1'b1 && bready));
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge sys_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid === 1'b1 && rready));
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		axi_wr(a, d, resp);
		check("bresp", {30'h0, resp}, {30'h0, er});
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] a,
		input logic [31:0] exp, input logic [1:0] er);
		axi_rd(a, rd_val, resp);
		check(name, rd_val, exp);
		check("rresp", {30'h0, resp}, {30'h0, er});
	endtask : rd_chk

	initial begin
		fail_count = 0;
		checks     = 0;
		cycles     = 0;
		reset      = 1'b1;
		awaddr     = 8'h00;
		awvalid    = 1'b0;
		wdata      = 32'h0;
		wstrb      = 4'h0;
		wvalid     = 1'b0;
		bready     = 1'b0;
		araddr     = 8'h00;
		arvalid    = 1'b0;
		rready     = 1'b0;
		wr_strb    = 4'hf;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd_chk("cfg", A_CFG, 32'h0, OK);
		rd_chk("preload", A_PRE, 32'h0000ffff, OK);
		rd_chk("count", A_CNT, 32'h0000ffff, OK);
		rd_chk("status", A_STS, 32'h0, OK);
		rd_chk("mask", A_MSK, 32'h0, OK);
		rd_chk("unmapped", 8'h14, 32'h0, ERR);
		// Preload stored while stopped, count untouched
		wr(A_PRE, 32'h3, OK);
		rd_chk("count", A_CNT, 32'h0000ffff, OK);
		rd_chk("preload", A_PRE, 32'h3, OK);
		wr(A_CFG, 32'h1, OK);
		rd_chk("count", A_CNT, 32'h3, OK);
		repeat (TICK) @(posedge sys_clk);
		rd_chk("count", A_CNT, 32'h2, OK);
		// Expiry with interrupt not allowed leaves flag clear
		repeat (4 * TICK) @(posedge sys_clk);
		rd_chk("status", A_STS, 32'h0, OK);
		check("irq", {31'h0, irq}, 32'h0);
		axi_rd(A_CNT, rd_val, resp);
		check("count_hi", {24'h0, rd_val[15:8]}, 32'hff);
		wr(A_MSK, 32'h1, OK);
		rd_chk("mask", A_MSK, 32'h1, OK);
		// Reload while running restarts from the new value
		wr(A_PRE, 32'h1, OK);
		rd_chk("count", A_CNT, 32'h1, OK);
		repeat (2 * TICK + 5) @(posedge sys_clk);
		rd_chk("status", A_STS, 32'h1, OK);
		check("irq", {31'h0, irq}, 32'h1);
		axi_rd(A_CNT, rd_val, resp);
		check("count_hi", {24'h0, rd_val[15:8]}, 32'hff);
		// Masking hides a set flag without clearing it
		wr(A_MSK, 32'h0, OK);
		check("irq", {31'h0, irq}, 32'h0);
		rd_chk("status", A_STS, 32'h1, OK);
		wr(A_MSK, 32'h1, OK);
		check("irq", {31'h0, irq}, 32'h1);
		wr(A_STS, 32'h0, OK);
		rd_chk("status", A_STS, 32'h1, OK);
		wr(A_STS, 32'h1, OK);
		rd_chk("status", A_STS, 32'h0, OK);
		check("irq", {31'h0, irq}, 32'h0);
		wr(8'h14, 32'h1, ERR);
		wr(A_CFG, 32'h0, OK);
		rd_chk("count", A_CNT, 32'h0000ffff, OK);
		// Count is read only; a write must not move it
		wr(A_CNT, 32'h1234, OK);
		rd_chk("count", A_CNT, 32'h0000ffff, OK);
		// Upper byte lane alone updates only the high half
		wr_strb = 4'h2;
		wr(A_PRE, 32'h0000abcd, OK);
		wr_strb = 4'hf;
		rd_chk("preload", A_PRE, 32'h0000ab01, OK);
		end_sim();
	end
endmodule : pcdt_timer_tb
`default_nettype wire
